// >>> common/ppr_pkg.sv
// constants for the password protected register map
package ppr_pkg;
  localparam logic [7:0]  ADDR_PW_ENTRY_LO = 8'h88;
  localparam logic [7:0]  ADDR_PW_ENTRY_HI = 8'h8b;
  localparam logic [7:0]  ADDR_SCRATCH_LO  = 8'h8c;
  localparam logic [7:0]  ADDR_SCRATCH_HI  = 8'h8e;
  localparam logic [7:0]  ADDR_STATUS      = 8'h8f;
  localparam logic [7:0]  ADDR_USER_KEY_LO = 8'h90;
  localparam logic [7:0]  ADDR_USER_KEY_HI = 8'h93;
  localparam logic [7:0]  ADDR_ADMIN_KEY_LO = 8'h94;
  localparam logic [7:0]  ADDR_ADMIN_KEY_HI = 8'h97;
  localparam logic [7:0]  ADDR_RES0_BANK0  = 8'h98;
  localparam logic [31:0] RST_KEY          = 32'h0000_0000;
  localparam logic [7:0]  RST_SCRATCH      = 8'h00;
  localparam logic [7:0]  RST_RES0_BANK0   = 8'h7f;
  localparam logic [7:0]  RST_RES0_BANK1   = 8'h7f;
  localparam logic [7:0]  RD_IDLE          = 8'h00;
  localparam logic [2:0]  HIZ_NONE         = 3'h0;
  localparam logic [2:0]  HIZ_ALL          = 3'h7;
  localparam logic [31:0] BYTE_MASK        = 32'h0000_00ff;
  localparam int          STAT_BANK_BIT    = 4;
  localparam int          STAT_OFF_BIT     = 0;
  localparam int          SCRATCH_N        = 3;
  typedef enum logic [1:0] {
    PPR_LVL_NONE  = 2'h0,
    PPR_LVL_USER  = 2'h1,
    PPR_LVL_ADMIN = 2'h3
  } ppr_level_t;
endpackage

// >>> verilog/ppr_regmap.sv
// password protected register map with status and resistor 0 bank select
`timescale 1ns/1ps
module ppr_regmap
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_bank_override_bit,
  input  wire logic [2:0] i_high_impedance_control,
  input  wire logic [7:0] i_res0_bank1,
  input  wire logic       i_bank_select_pin,
  input  wire logic       i_output_off_pin,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_valid,
  output logic      [7:0] o_res0_setting,
  output logic      [2:0] o_res_hiz,
  output logic      [1:0] o_level
);
  import ppr_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic bank_sync;
  logic off_sync;
  ppr_sync2
  #(
    .WIDTH (1)
  )
  u_bank_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_async   (i_bank_select_pin),
    .o_sync    (bank_sync)
  );
  ppr_sync2
  #(
    .WIDTH (1)
  )
  u_off_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_async   (i_output_off_pin),
    .o_sync    (off_sync)
  );

  // ==========================================================
  // storage
  logic [31:0] pw_entry;
  logic [31:0] user_key;
  logic [31:0] admin_key;
  logic [7:0]  scratch [SCRATCH_N];
  logic [7:0]  res0_bank0;

  // ==========================================================
  // access level
  wire user_match  = (pw_entry == user_key);
  wire admin_match = (pw_entry == admin_key);
  wire ppr_level_t level = admin_match ? PPR_LVL_ADMIN :
                           user_match  ? PPR_LVL_USER : PPR_LVL_NONE;
  wire is_admin = (level == PPR_LVL_ADMIN);

  // ==========================================================
  // address decode
  wire hit_entry   = (i_addr >= ADDR_PW_ENTRY_LO) && (i_addr <= ADDR_PW_ENTRY_HI);
  wire hit_scratch = (i_addr >= ADDR_SCRATCH_LO) && (i_addr <= ADDR_SCRATCH_HI);
  wire hit_status  = (i_addr == ADDR_STATUS);
  wire hit_user    = (i_addr >= ADDR_USER_KEY_LO) && (i_addr <= ADDR_USER_KEY_HI);
  wire hit_admin   = (i_addr >= ADDR_ADMIN_KEY_LO) && (i_addr <= ADDR_ADMIN_KEY_HI);
  wire hit_res0    = (i_addr == ADDR_RES0_BANK0);
  // byte lane: offset 0 is the most significant byte
  wire [1:0] lane    = i_addr[1:0];
  wire [4:0] lsb_pos = {~lane, 3'h0};
  wire [1:0] scr_idx = 2'(i_addr - ADDR_SCRATCH_LO);

  wire wr_entry   = i_wr_en && hit_entry;
  wire wr_scratch = i_wr_en && hit_scratch;
  wire wr_user    = i_wr_en && hit_user && is_admin;
  wire wr_admin   = i_wr_en && hit_admin && is_admin;
  wire wr_res0    = i_wr_en && hit_res0 && is_admin;

  function automatic logic [31:0] put_byte(input logic [31:0] word,
                                           input logic [4:0]  pos,
                                           input logic [7:0]  data);
    logic [31:0] mask;
    mask = BYTE_MASK << pos;
    put_byte = (word & ~mask) | (32'(data) << pos);
  endfunction

  wire [31:0] next_pw_entry  = wr_entry ? put_byte(pw_entry, lsb_pos, i_wr_data) : pw_entry;
  wire [31:0] next_user_key  = wr_user  ? put_byte(user_key, lsb_pos, i_wr_data) : user_key;
  wire [31:0] next_admin_key = wr_admin ? put_byte(admin_key, lsb_pos, i_wr_data) : admin_key;

  // ==========================================================
  // read mux: keys and entry never readable
  wire [7:0] status_byte = {3'h0, bank_sync, 3'h0, off_sync};
  wire [7:0] next_rd_data = hit_scratch ? scratch[scr_idx] :
                            hit_status  ? status_byte :
                            hit_res0    ? res0_bank0 :
                            RD_IDLE;
  wire [7:0] next_rd_byte = i_rd_en ? next_rd_data : RD_IDLE;
  wire use_bank1 = i_bank_override_bit | bank_sync;
  wire [7:0] next_res0 = use_bank1 ? i_res0_bank1 : res0_bank0;
  wire [2:0] next_hiz  = off_sync ? HIZ_ALL : i_high_impedance_control;

  // ==========================================================
  // scratch bytes, writable at any level
  genvar g;
  generate
    for (g = 0; g < SCRATCH_N; g++)
    begin : g_scratch
      wire scr_wr = wr_scratch && (scr_idx == 2'(g));
      ppr_byte_reg
      #(
        .RST_VAL (RST_SCRATCH)
      )
      u_byte
      (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (scr_wr),
        .i_data    (i_wr_data),
        .o_q       (scratch[g])
      );
    end
  endgenerate

  // ==========================================================
  // resistor 0 bank 0 byte, admin writes only
  ppr_byte_reg
  #(
    .RST_VAL (RST_RES0_BANK0)
  )
  u_res0_bank0
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_wr      (wr_res0),
    .i_data    (i_wr_data),
    .o_q       (res0_bank0)
  );

  // ==========================================================
  // password entry and key registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      pw_entry  <= RST_KEY;
      user_key  <= RST_KEY;
      admin_key <= RST_KEY;
    end
    else
    begin
      pw_entry  <= next_pw_entry;
      user_key  <= next_user_key;
      admin_key <= next_admin_key;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_rd_data  <= RD_IDLE;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_data  <= next_rd_byte;
      o_rd_valid <= i_rd_en;
    end
  end

  // ==========================================================
  // resistor 0 outputs and access level
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_res0_setting <= RST_RES0_BANK0;
      o_res_hiz      <= HIZ_NONE;
      o_level        <= PPR_LVL_ADMIN;
    end
    else
    begin
      o_res0_setting <= next_res0;
      o_res_hiz      <= next_hiz;
      o_level        <= level;
    end
  end
endmodule

// ==========================================================
// two flip-flop synchroniser for pin inputs
module ppr_sync2
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_ref_clk,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_ref_clk)
  begin
    meta   <= i_async;
    o_sync <= meta;
  end
endmodule

// ==========================================================
// byte register with its own reset value
module ppr_byte_reg
#(
  parameter logic [7:0] RST_VAL = 8'h00
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_q
);
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      o_q <= RST_VAL;
    else if (i_wr)
      o_q <= i_data;
  end
endmodule

// >>> test/ppr_regmap_asserts.sv
// concurrent checks on the register map ports
`timescale 1ns/1ps
module ppr_regmap_asserts (
  input wire logic       i_ref_clk, i_rst_b, i_wr_en, i_rd_en, i_bank_override_bit,
  input wire logic       i_bank_select_pin, i_output_off_pin, o_rd_valid,
  input wire logic [7:0] i_addr, i_wr_data, i_res0_bank1, o_rd_data, o_res0_setting,
  input wire logic [2:0] i_high_impedance_control, o_res_hiz,
  input wire logic [1:0] o_level
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  chk_rd_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  chk_idle_quiet: assert property (!i_rd_en |=> !o_rd_valid && o_rd_data == 8'h00)
    else $error("data without read");
  chk_entry_hidden: assert property (i_rd_en && i_addr inside {[8'h88:8'h8b]} |=> o_rd_data == 8'h00)
    else $error("entry readable");
  chk_keys_hidden: assert property (i_rd_en && i_addr inside {[8'h90:8'h97]} |=> o_rd_data == 8'h00)
    else $error("key readable");
  chk_status_zeros: assert property (i_rd_en && i_addr == 8'h8f |=> o_rd_data[7:5] == 3'h0 && o_rd_data[3:1] == 3'h0)
    else $error("status spare bits set");
  chk_hiz_forced: assert property (i_output_off_pin [*4] |=> o_res_hiz == 3'h7)
    else $error("off pin not forcing hiz");
  chk_bank_one: assert property ((i_bank_override_bit && $stable(i_res0_bank1)) [*4] |-> o_res0_setting == i_res0_bank1)
    else $error("bank 1 not selected");
  chk_scratch_rw: assert property (i_wr_en && i_addr == 8'h8c ##2 i_rd_en && i_addr == 8'h8c |=> o_rd_data == $past(i_wr_data, 3))
    else $error("scratch lost write");
  cover property (o_level == 2'h1);
  cover property (o_level == 2'h0);
  cover property (i_rd_en && i_addr == 8'h8f);
endmodule
bind ppr_regmap ppr_regmap_asserts u_chk (.*);

// >>> test/ppr_host.sv
// byte bus master model; idle bus shows inverted last values
`timescale 1ns/1ps
module ppr_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  output logic            o_wr, o_rd,
  output logic      [7:0] o_addr, o_data, o_q
);
  initial {o_wr, o_rd, o_addr, o_data, o_q} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk); #1 {o_addr, o_data, o_wr} = {a, d, 1'b1};
    @(posedge i_clk); #1 {o_addr, o_data, o_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk); #1 {o_addr, o_rd} = {a, 1'b1};
    @(posedge i_clk); #1 {o_addr, o_rd, o_q} = {~a, 1'b0, i_rd_data};
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the password protected register map
`timescale 1ns/1ps
module testbench;
  import ppr_pkg::*;
  logic i_ref_clk = 0, i_rst_b = 0, i_bank_override_bit = 0, i_bank_select_pin = 0;
  logic i_output_off_pin = 0, i_wr_en, i_rd_en, o_rd_valid;
  logic [7:0] i_addr, i_wr_data, i_res0_bank1 = 8'h00, o_rd_data, o_res0_setting, q, d;
  logic [2:0] i_high_impedance_control = 3'h0, o_res_hiz;
  logic [1:0] o_level;
  logic [31:0] uk, ak;
  int num_errors = 0, check_count = 0, cyc = 0, seed = 34216;
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  ppr_host host (.i_clk(i_ref_clk), .i_rd_data(o_rd_data), .o_wr(i_wr_en), .o_rd(i_rd_en),
                 .o_addr(i_addr), .o_data(i_wr_data), .o_q(q));
  ppr_regmap uut (.*);
  task chk(input string n, input logic [7:0] e, s);
    check_count++;
    if (s !== e) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end
  endtask
  task wr32(input logic [7:0] b, input logic [31:0] w);
    for (int i = 0; i < 4; i++) host.wr(8'(b + i), w[31 - 8 * i -: 8]);
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask
  function automatic logic [7:0] exp_sel(input logic ov, p, input logic [7:0] b0, b1);
    return (ov | p) ? b1 : b0;
  endfunction
  task final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_ref_clk) if (++cyc == 3000) begin num_errors++; final_report; end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    #1 i_rst_b = 1;
    uk = $random(seed) | 32'h100; ak = ~uk; d = 8'($random(seed));
    chk("level", PPR_LVL_ADMIN, o_level);
    host.rd(ADDR_RES0_BANK0); chk("res0", RST_RES0_BANK0, q);
    for (int i = 0; i < SCRATCH_N; i++) begin host.rd(8'(ADDR_SCRATCH_LO + i)); chk("scr", RST_SCRATCH, q); end
    wr32(ADDR_USER_KEY_LO, uk);
    // entry follows the admin key byte by byte so admin rights hold
    for (int i = 0; i < 4; i++) begin
      host.wr(8'(ADDR_ADMIN_KEY_LO + i), ak[31 - 8 * i -: 8]);
      host.wr(8'(ADDR_PW_ENTRY_LO + i), ak[31 - 8 * i -: 8]);
    end
    wr32(ADDR_PW_ENTRY_LO, 32'h0);
    chk("level", PPR_LVL_NONE, o_level);
    host.wr(ADDR_RES0_BANK0, ~d); host.rd(ADDR_RES0_BANK0); chk("res0", RST_RES0_BANK0, q);
    host.wr(ADDR_SCRATCH_LO, d); host.rd(ADDR_SCRATCH_LO); chk("scr", d, q);
    wr32(ADDR_PW_ENTRY_LO, uk); chk("level", PPR_LVL_USER, o_level);
    host.rd(ADDR_PW_ENTRY_HI); chk("entry", 8'h00, q);
    wr32(ADDR_PW_ENTRY_LO, ak); chk("level", PPR_LVL_ADMIN, o_level);
    host.wr(ADDR_RES0_BANK0, d); host.rd(ADDR_RES0_BANK0); chk("res0", d, q);
    host.rd(ADDR_USER_KEY_LO); chk("key", 8'h00, q);
    for (int i = 0; i < 8; i++) begin
      {i_bank_override_bit, i_bank_select_pin, i_output_off_pin} = 3'(i);
      i_high_impedance_control = 3'($random(seed)); i_res0_bank1 = 8'($random(seed));
      repeat (4) @(posedge i_ref_clk);
      host.rd(ADDR_STATUS);
      chk("stat", {3'h0, i_bank_select_pin, 3'h0, i_output_off_pin}, q);
      chk("hiz", i_output_off_pin ? 3'h7 : i_high_impedance_control, o_res_hiz);
      chk("sel", exp_sel(i_bank_override_bit, i_bank_select_pin, d, i_res0_bank1), o_res0_setting);
    end
    final_report;
  end
endmodule
